/* File: verilog/stdw_pkg.sv */
/*
  package for the split transfer descriptor word zero logic: field layout of word zero,
  interrupt layout constants, status bit positions and the carriers between the
  descriptor memory port and the split engine.
  assumes the host controller's descriptor memory presents 32-bit words.
*/
package stdw_pkg;

    localparam int unsigned WORD_W          = 32;
    localparam int unsigned EP_LSB_POS      = 31;
    localparam int unsigned LIMIT_HI        = 28;
    localparam int unsigned LIMIT_LO        = 18;
    localparam int unsigned LIMIT_W         = 11;
    localparam int unsigned COUNT_HI        = 17;
    localparam int unsigned COUNT_LO        = 3;
    localparam int unsigned COUNT_W         = 15;
    localparam int unsigned VALID_POS       = 0;
    localparam int unsigned EP_HI_W         = 3;
    localparam int unsigned EP_W            = 4;
    localparam int unsigned UFRAMES         = 8;
    localparam int unsigned UF_STATUS_W     = 3;
    localparam int unsigned INT_WORDS       = 8;
    localparam int unsigned ISO_WORDS       = 8;
    localparam int unsigned ST_XACT_ERR     = 0;
    localparam int unsigned ST_BABBLE       = 1;
    localparam int unsigned ST_UNDERRUN     = 2;
    localparam logic [COUNT_W-1:0] ISO_COUNT_MAX = 15'h03FF;
    localparam logic [WORD_W-1:0]  VALID_CLEAR_MASK = 32'hFFFF_FFFE;

    typedef enum logic {
        STDW_ISO,
        STDW_INT
    } stdw_layout_e;

    // decoded view of word zero
    typedef struct packed {
        logic                  endpoint_lsb;
        logic [LIMIT_W-1:0]    split_payload_limit;
        logic [COUNT_W-1:0]    transfer_byte_count;
        logic                  valid;
    } stdw_word0_s;

    // one start split request toward the transaction translator
    typedef struct packed {
        logic [EP_W-1:0]       endpoint_number;
        logic [LIMIT_W-1:0]    byte_len;
        logic [COUNT_W-1:0]    max_packet;
        stdw_layout_e          layout;
    } stdw_split_s;

endpackage

/* File: verilog/stdw_word0.sv */
/*
  split transfer descriptor word zero engine: fetches word zero of a descriptor,
  decodes it, issues start splits no larger than the payload limit, and writes back
  word zero with the valid flag cleared at completion or on a fatal error. also
  raises the halt flag from per-microframe status.
  assumes the descriptor memory answers a read one cycle after rd_en, that software
  programs limits and counts sensibly, and that the split engine gives ack or fatal.
*/
`timescale 1ns/1ps
module stdw_word0 #(
    parameter int unsigned ADDR_W = 16
) (
    input  wire logic                            clk,
    input  wire logic                            rst,
    input  wire logic                            start,
    input  wire logic [ADDR_W-1:0]               desc_addr,
    input  wire stdw_pkg::stdw_layout_e          layout,
    input  wire logic [stdw_pkg::EP_HI_W-1:0]    endpoint_hi,
    output logic                                 mem_rd_en,
    output logic                                 mem_wr_en,
    output logic [ADDR_W-1:0]                    mem_addr,
    output logic [stdw_pkg::WORD_W-1:0]          mem_wdata,
    input  wire logic [stdw_pkg::WORD_W-1:0]     mem_rdata,
    output logic                                 split_req,
    output stdw_pkg::stdw_split_s                split_info,
    input  wire logic                            split_ack,
    input  wire logic [stdw_pkg::LIMIT_W-1:0]    split_sent,
    input  wire logic                            split_fatal,
    input  wire logic [stdw_pkg::UFRAMES-1:0]    uf_stalled,
    output logic                                 halt_flag,
    output logic                                 busy,
    output logic                                 done
);

    typedef enum logic [2:0] {
        S_IDLE,
        S_READ,
        S_DECODE,
        S_SPLIT,
        S_WAIT,
        S_WRITE
    } stdw_state_e;

    stdw_state_e                    state_reg;
    stdw_pkg::stdw_word0_s          w0_reg;
    logic [stdw_pkg::WORD_W-1:0]    raw_reg;
    logic [stdw_pkg::COUNT_W-1:0]   remain_reg;
    logic [stdw_pkg::LIMIT_W-1:0]   chunk_next;
    stdw_pkg::stdw_word0_s          w0_next;

    // reserved bits are simply not picked out of the word
    always_comb
    begin
        w0_next.endpoint_lsb        = mem_rdata[stdw_pkg::EP_LSB_POS];
        w0_next.split_payload_limit = mem_rdata[stdw_pkg::LIMIT_HI:stdw_pkg::LIMIT_LO];
        w0_next.transfer_byte_count = mem_rdata[stdw_pkg::COUNT_HI:stdw_pkg::COUNT_LO];
        w0_next.valid               = mem_rdata[stdw_pkg::VALID_POS];
    end

    // a zero limit would never make progress, so it is treated as one byte
    always_comb
    begin
        chunk_next = w0_reg.split_payload_limit;
        if (chunk_next == '0)
        begin
            chunk_next = stdw_pkg::LIMIT_W'(1);
        end
        if ({{(stdw_pkg::COUNT_W-stdw_pkg::LIMIT_W){1'b0}}, chunk_next} > remain_reg)
        begin
            chunk_next = remain_reg[stdw_pkg::LIMIT_W-1:0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_reg  <= S_IDLE;
            w0_reg     <= '0;
            raw_reg    <= '0;
            remain_reg <= '0;
            split_req  <= 1'b0;
            split_info <= '0;
            busy       <= 1'b0;
            done       <= 1'b0;
        end
        else
        begin
            done      <= 1'b0;
            case (state_reg)
                S_IDLE:
                begin
                    if (start)
                    begin
                        busy      <= 1'b1;
                        state_reg <= S_READ;
                    end
                end
                S_READ:
                begin
                    state_reg <= S_DECODE;
                end
                S_DECODE:
                begin
                    w0_reg     <= w0_next;
                    raw_reg    <= mem_rdata;
                    remain_reg <= w0_next.transfer_byte_count;
                    // inactive descriptors are left untouched
                    if (!w0_next.valid)
                    begin
                        busy      <= 1'b0;
                        done      <= 1'b1;
                        state_reg <= S_IDLE;
                    end
                    else
                    begin
                        state_reg <= S_SPLIT;
                    end
                end
                S_SPLIT:
                begin
                    if (remain_reg == '0)
                    begin
                        state_reg <= S_WRITE;
                    end
                    else
                    begin
                        split_req                  <= 1'b1;
                        split_info.endpoint_number <= {endpoint_hi, w0_reg.endpoint_lsb};
                        split_info.byte_len        <= chunk_next;
                        split_info.max_packet      <= w0_reg.transfer_byte_count;
                        split_info.layout          <= layout;
                        state_reg                  <= S_WAIT;
                    end
                end
                S_WAIT:
                begin
                    if (split_fatal)
                    begin
                        split_req <= 1'b0;
                        state_reg <= S_WRITE;
                    end
                    else if (split_ack)
                    begin
                        split_req <= 1'b0;
                        if ({{(stdw_pkg::COUNT_W-stdw_pkg::LIMIT_W){1'b0}}, split_sent}
                            >= remain_reg)
                        begin
                            remain_reg <= '0;
                        end
                        else
                        begin
                            remain_reg <= remain_reg
                                - {{(stdw_pkg::COUNT_W-stdw_pkg::LIMIT_W){1'b0}}, split_sent};
                        end
                        state_reg <= S_SPLIT;
                    end
                end
                S_WRITE:
                begin
                    busy      <= 1'b0;
                    done      <= 1'b1;
                    state_reg <= S_IDLE;
                end
                default:
                begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end

    // memory port: read pulse on the start edge, write-back pulse in the cycle after the write state
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            mem_rd_en <= 1'b0;
            mem_wr_en <= 1'b0;
            mem_addr  <= '0;
            mem_wdata <= '0;
        end
        else
        begin
            mem_rd_en <= (state_reg == S_IDLE) && start;
            mem_wr_en <= (state_reg == S_WRITE);
            if (state_reg == S_IDLE && start)
            begin
                mem_addr <= desc_addr;
            end
            // reserved bits go back as read; only the valid flag is cleared
            if (state_reg == S_WRITE)
            begin
                mem_wdata <= raw_reg & stdw_pkg::VALID_CLEAR_MASK;
            end
        end
    end

    // halt is sticky for the descriptor; cleared at the next start
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            halt_flag <= 1'b0;
        end
        else if (busy && (|uf_stalled))
        begin
            halt_flag <= 1'b1;
        end
        else if (start && state_reg == S_IDLE)
        begin
            halt_flag <= 1'b0;
        end
    end

endmodule

/* File: sim/stdw_word0_properties.sv */
/* checker on the word zero engine ports
   assumes memory read data stands from the cycle after a read until the next read */
`timescale 1ns/1ps
module stdw_word0_properties #(
    parameter int unsigned ADDR_W = 16
) (
    input logic                   clk,
    input logic                   rst,
    input stdw_pkg::stdw_layout_e layout,
    input logic [2:0]             endpoint_hi,
    input logic                   mem_rd_en,
    input logic                   mem_wr_en,
    input logic [31:0]            mem_wdata,
    input logic [31:0]            mem_rdata,
    input logic                   split_req,
    input stdw_pkg::stdw_split_s  split_info,
    input logic                   split_fatal,
    input logic [7:0]             uf_stalled,
    input logic                   halt_flag,
    input logic                   busy
);
    logic        rd_reg;
    logic [31:0] w0_reg;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // shadow of word zero, taken where the engine decodes it
    always_ff @(posedge clk)
    begin
        rd_reg <= !rst && mem_rd_en;
        w0_reg <= rd_reg ? mem_rdata : w0_reg;
    end
    property p_len;
        split_req |-> split_info.byte_len <= w0_reg[28:18] || split_info.byte_len == 11'h001;
    endproperty
    a_len: assert property (p_len) else $error("split over limit");
    property p_mps;
        split_req |-> split_info.max_packet == w0_reg[17:3];
    endproperty
    a_mps: assert property (p_mps) else $error("packet size wrong");
    property p_ep;
        split_req |-> split_info.endpoint_number == {endpoint_hi, w0_reg[31]};
    endproperty
    a_ep: assert property (p_ep) else $error("endpoint wrong");
    property p_lay;
        split_req |-> split_info.layout == layout;
    endproperty
    a_lay: assert property (p_lay) else $error("layout wrong");
    property p_wb;
        mem_wr_en |-> mem_wdata == (w0_reg & 32'hFFFF_FFFE);
    endproperty
    a_wb: assert property (p_wb) else $error("write-back word wrong");
    property p_fatal;
        split_req && split_fatal |-> ##[1:4] mem_wr_en;
    endproperty
    a_fatal: assert property (p_fatal) else $error("no write-back after fatal");
    property p_halt;
        busy && |uf_stalled ##1 busy |-> halt_flag;
    endproperty
    a_halt: assert property (p_halt) else $error("halt not raised");
endmodule

bind stdw_word0 stdw_word0_properties #(.ADDR_W(ADDR_W)) u_stdw_word0_properties (.clk, .rst,
    .layout, .endpoint_hi, .mem_rd_en, .mem_wr_en, .mem_wdata, .mem_rdata, .split_req,
    .split_info, .split_fatal, .uf_stalled, .halt_flag, .busy);

/* File: sim/stdw_tt_model.sv */
/* descriptor memory and translator model
   assumes one descriptor in work at a time, word zero at address 0 */
`timescale 1ns/1ps
module stdw_tt_model (
    input  logic                  clk,
    input  logic                  rd,
    input  logic                  wr,
    input  logic [15:0]           addr,
    input  logic [31:0]           wd,
    output logic [31:0]           rdd = 32'h0000_0000,
    input  logic                  req,
    input  stdw_pkg::stdw_split_s info,
    output logic                  ack = 1'b0,
    output logic [10:0]           sent = 11'h000,
    input  logic                  fat_en,
    output logic                  fat = 1'b0,
    input  logic [3:0]            dly,
    input  logic                  pre,
    input  logic [31:0]           pw
);
    logic [31:0] mem [0:3];
    logic [3:0]  cnt = 4'h0;
    always @(posedge clk)
    begin
        rdd <= rd ? mem[addr[1:0]] : rdd;
        // preset of word zero by the bench takes the place of a software write
        if (pre)
            mem[0] <= pw;
        else if (wr)
            mem[addr[1:0]] <= wd;
    end
    // one answer per request, dly plus one cycles after it rises; sent toggles when it carries nothing
    always @(posedge clk)
    begin
        ack  <= req && !ack && !fat && cnt == dly && !fat_en;
        fat  <= req && !ack && !fat && cnt == dly && fat_en;
        cnt  <= (req && cnt != dly) ? cnt + 4'h1 : 4'h0;
        sent <= (cnt == dly) ? info.byte_len : ~sent;
    end
endmodule

/* File: sim/stdw_word0_tb_top.sv */
/* self-checking bench for the word zero engine
   assumes the model stands for descriptor memory and translator */
`timescale 1ns/1ps
module stdw_word0_tb_top;
    logic                   clk = 0, rst = 1, start = 0, rd, wr, req, ack, fat, halt, busy, done;
    stdw_pkg::stdw_layout_e lay = stdw_pkg::STDW_ISO;
    stdw_pkg::stdw_split_s  info;
    logic [2:0]             eph = 3'h0;
    logic [3:0]             dly = 4'h0;
    logic                   fat_en = 1'b0;
    logic [7:0]             stl = 8'h00;
    logic [10:0]            sent;
    logic [15:0]            addr;
    logic [31:0]            wd, rdd, pw = 32'h0000_0000;
    logic                   pre = 1'b0;
    int                     mismatches = 0, checks_done = 0, acks = 0;
    stdw_word0 #(.ADDR_W(16)) u_stdw_word0 (.clk, .rst, .start, .desc_addr(16'h0000),
        .layout(lay), .endpoint_hi(eph), .mem_rd_en(rd), .mem_wr_en(wr), .mem_addr(addr),
        .mem_wdata(wd), .mem_rdata(rdd), .split_req(req), .split_info(info), .split_ack(ack),
        .split_sent(sent), .split_fatal(fat), .uf_stalled(stl), .halt_flag(halt), .busy, .done);
    stdw_tt_model u_stdw_tt_model (.clk, .rd, .wr, .addr, .wd, .rdd, .req, .info, .ack, .sent,
        .fat_en, .fat, .dly, .pre, .pw);
    always #5 clk = ~clk;
    always @(posedge clk) if (ack) acks++;
    task automatic close_out(input int t);
        mismatches += t;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cfg(input stdw_pkg::stdw_layout_e l, input logic [2:0] e, input logic [3:0] d,
        input logic f, input logic [7:0] s);
        {eph, dly, fat_en, stl} = {e, d, f, s};
        lay = l;
    endtask
    // word zero is preset through the model's own port, reserved bits zero
    task automatic load(input logic [31:0] w);
        pw  = w;
        pre = 1'b1;
        @(negedge clk) pre = 1'b0;
    endtask
    // the write-back expectation follows from the word alone; acks is counted by one process only
    task automatic run(input string name, input logic [31:0] w, input int n, input logic hf);
        int i;
        int a0;
        load(w);
        a0 = acks;
        start = 1'b1;
        @(negedge clk) start = 1'b0;
        cmp("busy", 1'b1, busy);
        for (i = 0; i < 300 && done !== 1'b1; i++) @(negedge clk);
        if (done !== 1'b1)
            close_out(1);
        cmp("halt_flag", hf, halt);
        cmp("busy", 1'b0, busy);
        repeat (2) @(negedge clk);
        cmp("split count", n, acks - a0);
        cmp("word0", w[0] ? w & 32'hFFFF_FFFE : w, u_stdw_tt_model.mem[0]);
        $display("%s finished", name);
    endtask
    task automatic t_out; // 400 bytes over a 188 limit, back-to-back answers
        cfg(stdw_pkg::STDW_ISO, 3'h5, 4'h0, 1'b0, 8'h00);
        run("t_out", {1'b1, 2'b00, 11'h0BC, 15'h0190, 2'b00, 1'b1}, 3, 1'b0);
    endtask
    task automatic t_in; // 1023 bytes over a 192 limit, slow translator
        cfg(stdw_pkg::STDW_INT, 3'h2, 4'h7, 1'b0, 8'h00);
        run("t_in", {1'b0, 2'b00, 11'h0C0, 15'h03FF, 2'b00, 1'b1}, 6, 1'b0);
    endtask
    task automatic t_small; // limit equals total, one microframe stalled
        cfg(stdw_pkg::STDW_ISO, 3'h7, 4'h1, 1'b0, 8'h10);
        run("t_small", {1'b1, 2'b00, 11'h064, 15'h0064, 2'b00, 1'b1}, 1, 1'b1);
    endtask
    task automatic t_off; // descriptor not valid, also clears the halt left behind
        cfg(stdw_pkg::STDW_ISO, 3'h1, 4'h0, 1'b0, 8'h00);
        run("t_off", {1'b0, 2'b00, 11'h064, 15'h0064, 2'b00, 1'b0}, 0, 1'b0);
    endtask
    task automatic t_fatal; // translator fails the first start split
        cfg(stdw_pkg::STDW_ISO, 3'h3, 4'h2, 1'b1, 8'h00);
        run("t_fatal", {1'b1, 2'b00, 11'h0BC, 15'h0190, 2'b00, 1'b1}, 0, 1'b0);
    endtask
    // reset while a split waits: request and busy drop, word zero stays valid
    task automatic t_reset;
        int          i;
        logic [31:0] w;
        w = {1'b1, 2'b00, 11'h0BC, 15'h0190, 2'b00, 1'b1};
        cfg(stdw_pkg::STDW_ISO, 3'h4, 4'h7, 1'b0, 8'h00);
        load(w);
        start = 1'b1;
        @(negedge clk) start = 1'b0;
        for (i = 0; i < 20 && req !== 1'b1; i++) @(negedge clk);
        if (req !== 1'b1)
            close_out(1);
        rst = 1'b1;
        @(negedge clk) rst = 1'b0;
        cmp("split_req", 1'b0, req);
        cmp("busy", 1'b0, busy);
        repeat (2) @(negedge clk);
        cmp("word0", w, u_stdw_tt_model.mem[0]);
        $display("t_reset finished");
    endtask
    initial
    begin
        repeat (3) @(negedge clk);
        rst = 1'b0;
        t_out();
        t_in();
        t_reset();
        t_small();
        t_off();
        t_fatal();
        close_out(0);
    end
endmodule
